// ===== logic/trace_frame_formatter_defs.svh
/*
  Constants for the trace frame formatter: frame layout, special identifiers,
  FIFO sizing and the padding wait time.
  Assumes the system clock runs at 10 MHz.
*/
`ifndef TRACE_FRAME_FORMATTER_DEFS_SVH
`define TRACE_FRAME_FORMATTER_DEFS_SVH

// frame layout
`define FRAME_BYTES 16
`define FRAME_AUX_POS 4'hF
`define FRAME_LAST_MIXED 4'hE
`define FRAME_FIRST_POS 4'h0
`define MIXED_FLAG_BIT 0
`define FLAG_ID 1'b1
`define FLAG_DATA 1'b0
`define AUX_NOW 1'b0
`define AUX_LATER 1'b1

// special source identifiers
`define NULL_ID 7'h00
`define PAD_BYTE 8'h00

// serialiser
`define FRAME_BITS_LEFT 8'h7F
`define RAW_BITS_LEFT 8'h07
`define BITS_NONE 8'h00

// input buffering
`define SRC_FIFO_DEPTH 8
`define SRC_FIFO_WIDTH 15

// padding: how long a started frame waits for trace before it is padded
`define CLK_PERIOD_NS 100
`define PAD_WAIT_NS 6400
`define PAD_WAIT_CYC ((`PAD_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== logic/trace_frame_formatter_pkg.sv
/*
  Types used by the trace frame formatter, including the entry it reads from its input FIFO.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package trace_frame_formatter_pkg;

  typedef enum logic {
    MODE_FRAMED,
    MODE_RAW
  } mode_t;

  typedef struct packed {
    logic [6:0] id;
    logic [7:0] data;
  } entry_t;

  typedef struct packed {
    mode_t mode;
    logic [3:0] pos;
    logic [15:0][7:0] frame;
    logic frame_full;
    logic [6:0] cur_id;
    logic id_known;
    logic pad;
    logic [15:0] wait_cnt;
    entry_t h0;
    logic h0_v;
    entry_t h1;
    logic h1_v;
    logic [127:0] shreg;
    logic [7:0] sh_cnt;
    logic out_bit;
    logic out_valid;
    logic out_first;
  } fmt_state_t;

endpackage

// ===== logic/trace_byte_fifo.sv
/*
  Small FIFO for tagged trace bytes, with a registered output stage.
  Assumes one clock and a synchronous active-low reset; DEPTH of two or more.
*/
`timescale 1ns/1ns
module trace_byte_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] count;
    logic room;
    logic out_v;
    logic [WIDTH-1:0] out_d;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic push;
  logic pop;

  always_comb begin
    next_s = s;
    push = in_valid && s.room;
    pop = (s.count != '0) && (!s.out_v || out_ready);
    if (s.out_v && out_ready) begin
      next_s.out_v = 1'b0;
    end
    if (pop) begin
      next_s.out_d = s.mem[s.rd];
      next_s.out_v = 1'b1;
      next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + AW'(1);
    end
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + AW'(1);
    end
    next_s.count = s.count + CW'(push) - CW'(pop);
    // room is a flop so the source sees a clean ready
    next_s.room = (next_s.count != CW'(DEPTH));
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s <= '0;
      s.room <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready = s.room;
  assign out_valid = s.out_v;
  assign out_data = s.out_d;
endmodule

// ===== logic/trace_frame_formatter.sv
/*
  Trace frame formatter: merges tagged trace bytes into 16-byte frames and
  shifts them out one bit per clock, least significant bit first. With
  formatting off, raw bytes of a single source are shifted out instead.
  Assumes the source and format_enable run on clk_sys; the serial output is
  taken every cycle in which trace_bit_valid is high.
*/
`timescale 1ns/1ns
`include "trace_frame_formatter_defs.svh"

// Overview of operation
// RL1: output is a run of 16-byte frames with fixed byte roles.
// RL2: odd bytes 1-13 are data, even bytes 0-14 mixed, byte 15 auxiliary.
// RL3: mixed byte bit 0 flags ID (1) or data bits 7:1 (0).
// RL4: for a data mixed byte, its auxiliary bit holds data bit 0.
// RL5: auxiliary bit k serves the mixed byte at position 2k.
// RL6: ID change aux 0 means next byte is new source; 1 means old.
// RL7: an ID change at byte 14 has aux bit 7 zero; applies next frame.
// RL8: the decoder ignores aux bit 7 after an ID change at byte 14.
// RL9: after each ID change, at least one data byte before another change.
// RL10: frames leave bit 0 of byte 0 first, ascending through byte 15.
// RL11: formatting off passes raw single-source bytes with no framing.
// RL12: ID 0x00 pads short frames; data after it is discarded.
// RL13: a byte whose ID differs from the current one forces an ID change.
// RL14: after reset, start at byte 0 with no ID in effect.
module trace_frame_formatter #(
  parameter int FIFO_DEPTH = `SRC_FIFO_DEPTH,
  parameter int PAD_WAIT = `PAD_WAIT_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // trace source
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [7:0] src_data,
  input wire logic [6:0] src_id,
  // control and status
  input wire logic format_enable,
  output logic framing_on,
  // serial trace output
  output logic trace_bit,
  output logic trace_bit_valid,
  output logic frame_start
);

  trace_frame_formatter_pkg::fmt_state_t s;
  trace_frame_formatter_pkg::fmt_state_t next_s;
  trace_frame_formatter_pkg::entry_t fifo_entry;
  logic fifo_valid;
  logic fifo_take;
  logic consume;
  logic advance;
  logic [7:0] byte_out;
  logic [2:0] aux_idx;
  logic even_pos;
  logic timed_out;

  trace_byte_fifo #(
    .WIDTH(`SRC_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) trace_byte_fifo_inst (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .in_valid(src_valid),
    .in_ready(src_ready),
    .in_data({src_id, src_data}),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_entry)
  );

  always_comb begin
    next_s = s;
    consume = 1'b0;
    advance = 1'b0;
    byte_out = `PAD_BYTE;
    aux_idx = s.pos[3:1];
    even_pos = !s.pos[0];
    timed_out = (s.wait_cnt >= 16'(PAD_WAIT));

    // holding slots refill from the FIFO; blocked while padding, and in the
    // cycle a pad starts, so no real trace gets written under the null source
    fifo_take = fifo_valid && !s.pad && !timed_out && !(s.h0_v && s.h1_v);

    // mode changes only at byte 0 with no frame or bits pending, even in the cycle byte 0 is written
    if (s.pos == `FRAME_FIRST_POS && !s.frame_full && s.sh_cnt == `BITS_NONE) begin
      next_s.mode = format_enable ? trace_frame_formatter_pkg::MODE_FRAMED
                                  : trace_frame_formatter_pkg::MODE_RAW;
      if (!format_enable) begin
        next_s.id_known = 1'b0;
      end
    end

    // frame assembly
    if (s.mode == trace_frame_formatter_pkg::MODE_FRAMED && !s.frame_full) begin
      if (s.pos == `FRAME_AUX_POS) begin
        next_s.frame_full = 1'b1; // RL1
        next_s.pos = `FRAME_FIRST_POS;
        next_s.pad = 1'b0;
        next_s.wait_cnt = '0;
      end else if (even_pos) begin
        if (s.pad) begin
          byte_out = `PAD_BYTE; // RL12
          next_s.frame[`FRAME_AUX_POS][aux_idx] = `AUX_NOW;
          advance = 1'b1;
        end else if (s.h0_v && (!s.id_known || s.h0.id != s.cur_id)) begin
          byte_out = {s.h0.id, `FLAG_ID}; // RL13 RL14 RL3
          next_s.frame[`FRAME_AUX_POS][aux_idx] = `AUX_NOW; // RL6 RL7
          next_s.cur_id = s.h0.id;
          next_s.id_known = 1'b1;
          advance = 1'b1;
        end else if (s.h0_v && (s.pos == `FRAME_LAST_MIXED || (s.h1_v && s.h1.id == s.cur_id))) begin
          byte_out = {s.h0.data[7:1], `FLAG_DATA}; // RL3
          next_s.frame[`FRAME_AUX_POS][aux_idx] = s.h0.data[0]; // RL4 RL5
          consume = 1'b1;
          advance = 1'b1;
        end else if (s.h0_v && s.h1_v) begin
          // announce the next source early; the held byte still goes out
          // in the following data slot under the old source
          byte_out = {s.h1.id, `FLAG_ID}; // RL13 RL3
          next_s.frame[`FRAME_AUX_POS][aux_idx] = `AUX_LATER; // RL6 RL9
          next_s.cur_id = s.h1.id;
          advance = 1'b1;
        end else if (timed_out && s.pos != `FRAME_FIRST_POS) begin
          byte_out = {`NULL_ID, `FLAG_ID}; // RL12
          // with a byte still held it goes out first under the old source
          next_s.frame[`FRAME_AUX_POS][aux_idx] = s.h0_v ? `AUX_LATER : `AUX_NOW; // RL6 RL7
          next_s.cur_id = `NULL_ID;
          next_s.id_known = 1'b1;
          next_s.pad = 1'b1;
          advance = 1'b1;
        end else if (s.pos != `FRAME_FIRST_POS) begin
          next_s.wait_cnt = s.wait_cnt + 16'h0001;
        end
      end else begin
        if (s.h0_v) begin
          byte_out = s.h0.data; // RL2
          consume = 1'b1;
          advance = 1'b1;
        end else if (s.pad) begin
          byte_out = `PAD_BYTE; // RL12
          advance = 1'b1;
        end
      end
      if (advance) begin
        next_s.frame[s.pos] = byte_out; // RL2
        next_s.pos = s.pos + 4'h1;
        next_s.wait_cnt = '0;
      end
    end

    // serialiser, one bit per clock
    next_s.out_first = 1'b0;
    if (s.sh_cnt != `BITS_NONE) begin
      next_s.out_bit = s.shreg[0]; // RL10
      next_s.out_valid = 1'b1;
      next_s.shreg = {1'b0, s.shreg[127:1]};
      next_s.sh_cnt = s.sh_cnt - 8'h01;
    end else if (s.frame_full) begin
      next_s.out_bit = s.frame[0][0]; // RL10
      next_s.out_valid = 1'b1;
      next_s.out_first = 1'b1;
      next_s.shreg = s.frame >> 1;
      next_s.sh_cnt = `FRAME_BITS_LEFT;
      next_s.frame_full = 1'b0;
    end else if (s.mode == trace_frame_formatter_pkg::MODE_RAW && s.h0_v) begin
      // raw byte: no identifier, no framing
      next_s.out_bit = s.h0.data[0]; // RL11
      next_s.out_valid = 1'b1;
      next_s.shreg = {120'h0, 1'b0, s.h0.data[7:1]};
      next_s.sh_cnt = `RAW_BITS_LEFT;
      consume = 1'b1;
    end else begin
      next_s.out_valid = 1'b0;
      next_s.out_bit = 1'b0;
    end

    // holding slots: shift on consume, then refill the first empty one
    if (consume) begin
      next_s.h0 = s.h1;
      next_s.h0_v = s.h1_v;
      next_s.h1_v = 1'b0;
    end
    if (fifo_take) begin
      if (!next_s.h0_v) begin
        next_s.h0 = fifo_entry;
        next_s.h0_v = 1'b1;
      end else begin
        next_s.h1 = fifo_entry;
        next_s.h1_v = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s <= '0; // RL14
    end else begin
      s <= next_s;
    end
  end

  assign trace_bit = s.out_bit;
  assign trace_bit_valid = s.out_valid;
  assign frame_start = s.out_first;
  assign framing_on = (s.mode == trace_frame_formatter_pkg::MODE_FRAMED);
endmodule

// ===== testbench/trace_frame_formatter_assertions.sv
/* port checks for the trace frame formatter
   assumes binding to every formatter instance */
`timescale 1ns/1ns
module trace_frame_formatter_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // watched outputs
  input wire logic src_ready,
  input wire logic framing_on,
  input wire logic trace_bit,
  input wire logic trace_bit_valid,
  input wire logic frame_start
);
  logic [6:0] cnt;
  logic seen;
  logic f14;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // bit index in the frame; wraps to 0 after bit 127
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cnt <= 7'h00;
      seen <= 1'b0;
      f14 <= 1'b0;
    end else begin
      if (frame_start) cnt <= 7'h01;
      else if (cnt != 7'h00) cnt <= cnt + 7'h01;
      if (frame_start) seen <= 1'b1;
      if (cnt == 7'h70) f14 <= trace_bit;
    end
  end
  chk_frame_whole: assert property (cnt != 7'h00 |-> trace_bit_valid && !frame_start)
    else $error("frame broken before bit 127");
  chk_start_aligned: assert property (frame_start |-> cnt == 7'h00 && trace_bit_valid)
    else $error("frame start off boundary");
  chk_first_id: assert property (frame_start && !seen |-> trace_bit)
    else $error("first frame lacks id change");
  chk_aux_seven: assert property (cnt == 7'h7F && f14 |-> !trace_bit)
    else $error("aux bit 7 set after id at byte 14");
  chk_raw_nostart: assert property (!framing_on |-> !frame_start)
    else $error("frame start in raw mode");
  chk_raw_byte: assert property (!framing_on && $rose(trace_bit_valid) |-> trace_bit_valid [*8])
    else $error("raw byte shorter than 8 bits");
  chk_mode_hold: assert property ((frame_start || cnt != 7'h00) && cnt != 7'h7F |=> $stable(framing_on))
    else $error("mode changed inside a frame");
  chk_reset_quiet: assert property ($rose(nrst) |-> src_ready && framing_on && !trace_bit_valid)
    else $error("bad state after reset");
endmodule
bind trace_frame_formatter trace_frame_formatter_assertions trace_frame_formatter_assertions_inst (
  .clk_sys(clk_sys),
  .nrst(nrst),
  .src_ready(src_ready),
  .framing_on(framing_on),
  .trace_bit(trace_bit),
  .trace_bit_valid(trace_bit_valid),
  .frame_start(frame_start)
);

// ===== testbench/trace_capture_analyser.sv
/* frame decoder standing for the trace capture analyser
   assumes bits arrive on clk_sys whenever trace_bit_valid is high */
`timescale 1ns/1ns
module trace_capture_analyser (
  // clock
  input wire logic clk_sys,
  // serial trace
  input wire logic trace_bit,
  input wire logic trace_bit_valid,
  input wire logic frame_start
);
  logic [127:0] fr;
  int n = 0;
  int seq_err = 0;
  logic [6:0] cur = 7'h00;
  logic [6:0] nxt = 7'h00;
  logic pend = 1'b0;
  logic fresh = 1'b0;
  logic [14:0] got[$];
  // data under the null source is padding and dropped
  task automatic put(input logic [7:0] b);
    if (cur != 7'h00) got.push_back({cur, b});
    fresh = 1'b0;
    if (pend) begin
      cur = nxt;
      fresh = 1'b1;
    end
    pend = 1'b0;
  endtask
  task automatic decode();
    logic [7:0] b;
    logic ax;
    for (int p = 0; p < 15; p++) begin
      b = fr[p*8 +: 8];
      ax = fr[120 + p/2];
      if (p % 2 == 1) put(b);
      else if (!b[0]) put({b[7:1], ax});
      else begin
        nxt = b[7:1];
        pend = ax && p != 14;
        // a deferred change lets the old source keep the next byte, so only
        // an immediate change can leave the current source without data
        if (!pend) begin
          if (fresh) seq_err++;
          cur = nxt;
          fresh = 1'b1;
        end
      end
    end
  endtask
  // bits outside a frame (raw mode) are not framed trace
  always @(posedge clk_sys) begin
    if (trace_bit_valid && (frame_start || n > 0)) begin
      fr[n] = trace_bit;
      n = (n + 1) % 128;
      if (n == 0) decode();
    end
  end
endmodule

// ===== testbench/trace_frame_formatter_tb.sv
/* testbench for the trace frame formatter: framed traffic, padding, raw mode
   assumes the analyser model decodes every frame */
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module trace_frame_formatter_tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic src_valid = 1'b0;
  logic [7:0] src_data = 8'h00;
  logic [6:0] src_id = 7'h01;
  logic format_enable = 1'b1;
  logic src_ready, framing_on, trace_bit, trace_bit_valid, frame_start;
  logic full_seen = 1'b0;
  logic [14:0] sent[$];
  int n_mismatch = 0;
  int cmp_count = 0;
  always #50 clk_sys = ~clk_sys;
  // short pad wait keeps the run brief
  trace_frame_formatter #(.PAD_WAIT(8)) trace_frame_formatter_inst (.clk_sys(clk_sys), .nrst(nrst),
    .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data), .src_id(src_id),
    .format_enable(format_enable), .framing_on(framing_on), .trace_bit(trace_bit),
    .trace_bit_valid(trace_bit_valid), .frame_start(frame_start));
  trace_capture_analyser trace_capture_analyser_inst (.clk_sys(clk_sys), .trace_bit(trace_bit),
    .trace_bit_valid(trace_bit_valid), .frame_start(frame_start));
  task automatic step();
    @(posedge clk_sys);
    #5;
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic give_up();
    n_mismatch++;
    conclude();
  endtask
  // holds the byte until ready is seen before an edge
  task automatic send(input logic [6:0] id, input logic [7:0] d);
    int k;
    src_valid = 1'b1;
    src_id = id;
    src_data = d;
    sent.push_back({id, d});
    for (k = 0; k < 500 && src_ready !== 1'b1; k++) step();
    if (k == 500) give_up();
    if (k > 0) full_seen = 1'b1;
    step();
  endtask
  task automatic framed_traffic();
    int k;
    logic [7:0] a[12] = '{8'hAA, 8'hA6, 8'hA7, 8'hA8, 8'h55, 8'h52, 8'h53, 8'h54, 8'hCA, 8'hC6, 8'hC7, 8'hC8};
    for (k = 0; k < 12; k++) send((k < 4 || k > 7) ? 7'h03 : 7'h15, a[k]);
    // single bytes per source put an id change on every even slot
    for (k = 0; k < 9; k++) send(k[0] ? 7'h09 : 7'h07, 8'h10 + 8'(k));
    // a long run of one source fills the FIFO while frames wait to shift
    for (k = 0; k < 24; k++) send(7'h0B, 8'h40 + 8'(k));
    src_valid = 1'b0;
    for (k = 0; k < 3000 && trace_capture_analyser_inst.got.size() < sent.size(); k++) step();
    if (k == 3000) give_up();
    `CHK(trace_capture_analyser_inst.got.size(), sent.size())
    foreach (sent[i]) `CHK(trace_capture_analyser_inst.got[i], sent[i])
    `CHK(trace_capture_analyser_inst.seq_err, 0)
    `CHK(full_seen, 1'b1)
  endtask
  task automatic raw_traffic();
    int k;
    logic [7:0] b;
    format_enable = 1'b0;
    for (k = 0; k < 1000 && framing_on !== 1'b0; k++) step();
    if (k == 1000) give_up();
    send(7'h02, 8'hB4);
    src_valid = 1'b0;
    for (k = 0; k < 100 && trace_bit_valid !== 1'b1; k++) step();
    if (k == 100) give_up();
    for (k = 0; k < 8; k++) begin
      b[k] = trace_bit;
      step();
    end
    `CHK(b, 8'hB4)
    format_enable = 1'b1;
    for (k = 0; k < 100 && framing_on !== 1'b1; k++) step();
    `CHK(framing_on, 1'b1)
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    #5;
    nrst = 1'b1;
    step();
    `CHK(src_ready, 1'b1)
    `CHK(trace_bit_valid, 1'b0)
    `CHK(framing_on, 1'b1)
    framed_traffic();
    raw_traffic();
    conclude();
  end
endmodule
